// ===== bdc_top.sv
// cyclic exchange, double check and parameter pacing of the bridge
`timescale 1ns/100ps
`include "bdc_defs.svh"
module bdc_top #(
    parameter int NIN = 256,
    parameter int FIFO_DEPTH = 16,
    parameter int CYC64 = `BDC_US2CYC(`BDC_CYC64_US),
    parameter int CYC128 = `BDC_US2CYC(`BDC_CYC128_US),
    parameter int CYC256 = `BDC_US2CYC(`BDC_CYC256_US),
    parameter int CYC512 = `BDC_US2CYC(`BDC_CYC512_US),
    parameter int BRIDGE_CYC = `BDC_US2CYC(`BDC_BRIDGE_US)
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire bdc_pkg::bdc_pts_t cfg_points,
    input wire logic [4:0] cfg_words_wr,
    input wire logic cfg_save,
    input wire logic [NIN-1:0] rx_data,
    input wire logic rx_done,
    output logic cycle_start,
    output logic [NIN-1:0] in_area,
    output logic [15:0] out_word,
    output logic out_word_valid,
    input wire logic out_word_ready,
    input wire logic [15:0] host_word,
    input wire logic host_word_valid,
    output logic host_word_ready,
    input wire logic [7:0] conn_ids,
    input wire logic [7:0] tgt_ids,
    input wire logic prm_rd_req,
    input wire logic prm_wr_req,
    output logic prm_busy,
    output logic prm_done,
    output logic prm_auto_tick,
    output logic [4:0] words_active
);
    localparam int NWORD = NIN / `BDC_WORD_BITS;
    localparam int WW = `BDC_WORD_BITS;

    typedef struct packed {
        logic [31:0] cyc_cnt;
        logic [31:0] cyc_len;
        logic cyc_pulse;
        logic [4:0] words_saved;
        logic [4:0] words_used;
        logic applied;
        bdc_pkg::bdc_pst_t pst;
        logic [15:0] pcnt;
        logic [15:0] plim;
        logic [15:0] acnt;
        logic prm_done;
        logic prm_auto;
        logic [NIN-1:0] area;
        logic [31:0] bcnt;
        logic bpend;
        logic [15:0] oword;
        logic ovalid;
    } bdc_st_t;
    bdc_st_t s_r, s_nxt;

    logic sample;
    logic [NIN-1:0] bit_val, word_val;
    logic [15:0] f_data;
    logic f_valid, f_ready;

    initial begin
        if (NIN < WW || NIN % WW != 0 || NWORD > 16)
            $error("input width must be 16 to 256, multiple of 16");
    end

    // a cycle pulse takes a sample only if the slaves report a full sweep
    assign sample = s_r.cyc_pulse && rx_done;

    // every bit gets a bit cell and every word a word cell
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_bit
            bdc_cell #(.WIDTH(1)) u_bit (
                .mclk(mclk),
                .nrst(nrst),
                .sample(sample),
                .rx_val(rx_data[gi]),
                .valid_val(bit_val[gi])
            );
        end
        for (gi = 0; gi < NWORD; gi++) begin : g_word
            bdc_cell #(.WIDTH(WW)) u_word (
                .mclk(mclk),
                .nrst(nrst),
                .sample(sample),
                .rx_val(rx_data[gi*WW +: WW]),
                .valid_val(word_val[gi*WW +: WW])
            );
        end
    endgenerate

    // outputs to the line pass a 16-word buffer; a stalled line stalls host
    bdc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .in_data(host_word),
        .in_valid(host_word_valid),
        .in_ready(host_word_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );
    assign f_ready = !s_r.ovalid || out_word_ready;

    always_comb begin
        s_nxt = s_r;
        s_nxt.cyc_pulse = 1'b0;
        s_nxt.prm_done = 1'b0;
        s_nxt.prm_auto = 1'b0;
        // cycle length follows point count
        case (cfg_points)
            bdc_pkg::BDC_PTS64: s_nxt.cyc_len = CYC64;
            bdc_pkg::BDC_PTS128: s_nxt.cyc_len = CYC128;
            bdc_pkg::BDC_PTS256: s_nxt.cyc_len = CYC256;
            bdc_pkg::BDC_PTS512: s_nxt.cyc_len = CYC512;
            default: s_nxt.cyc_len = CYC64;
        endcase
        if (s_r.cyc_cnt + 32'h1 >= s_r.cyc_len) begin
            s_nxt.cyc_cnt = '0;
            s_nxt.cyc_pulse = 1'b1;
        end else begin
            s_nxt.cyc_cnt = s_r.cyc_cnt + 32'h1;
        end
        // setting is saved now, but reset clears it, so words_used takes 0 once after reset release
        if (cfg_save)
            s_nxt.words_saved = cfg_words_wr;
        if (!s_r.applied) begin
            s_nxt.words_used = s_r.words_saved;
            s_nxt.applied = 1'b1;
        end
        // leading words use the word check, the rest per bit
        if (sample) begin
            s_nxt.bpend = 1'b1;
            s_nxt.bcnt = '0;
        end else if (s_r.bpend) begin
            if (s_r.bcnt + 32'h1 >= BRIDGE_CYC) begin
                s_nxt.bpend = 1'b0;
                for (int w = 0; w < NWORD; w++) begin
                    if (w < s_r.words_used)
                        s_nxt.area[w*WW +: WW] = word_val[w*WW +: WW];
                    else
                        s_nxt.area[w*WW +: WW] = bit_val[w*WW +: WW];
                end
            end else begin
                s_nxt.bcnt = s_r.bcnt + 32'h1;
            end
        end
        // output words leave one per clock whenever the line takes them
        if (f_ready && f_valid) begin
            s_nxt.oword = f_data;
            s_nxt.ovalid = 1'b1;
        end else if (out_word_ready) begin
            s_nxt.ovalid = 1'b0;
        end
        // parameter pacing counted in cycles, apart from I/O
        if (s_r.cyc_pulse) begin
            if (s_r.acnt + 16'h1 >= 16'(conn_ids) * 16'(`BDC_AUTO_MULT)) begin
                s_nxt.acnt = '0;
                s_nxt.prm_auto = (conn_ids != 8'h00);
            end else begin
                s_nxt.acnt = s_r.acnt + 16'h1;
            end
        end
        case (s_r.pst)
            bdc_pkg::BDC_PIDLE: begin
                s_nxt.pcnt = '0;
                if (prm_rd_req) begin
                    s_nxt.pst = bdc_pkg::BDC_PREAD;
                    s_nxt.plim = 16'(tgt_ids) * 16'(`BDC_READ_MULT);
                end else if (prm_wr_req) begin
                    s_nxt.pst = bdc_pkg::BDC_PWRITE;
                    s_nxt.plim = 16'(tgt_ids) * 16'(`BDC_WRITE_MULT);
                end
            end
            bdc_pkg::BDC_PREAD, bdc_pkg::BDC_PWRITE: begin
                if (s_r.cyc_pulse)
                    s_nxt.pcnt = s_r.pcnt + 16'h1;
                if (s_r.pcnt >= s_r.plim) begin
                    s_nxt.pst = bdc_pkg::BDC_PIDLE;
                    s_nxt.prm_done = 1'b1;
                end
            end
            default: s_nxt.pst = bdc_pkg::BDC_PIDLE;
        endcase
    end

    // one register stage holds all state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cycle_start = s_r.cyc_pulse;
    assign in_area = s_r.area;
    assign out_word = s_r.oword;
    assign out_word_valid = s_r.ovalid;
    assign prm_busy = (s_r.pst != bdc_pkg::BDC_PIDLE);
    assign prm_done = s_r.prm_done;
    assign prm_auto_tick = s_r.prm_auto;
    assign words_active = s_r.words_used;
endmodule : bdc_top

// ===== bdc_defs.svh
// constants for the bridge double check and cycle timing block
// Overview of operation
// - an input updates only after equal values in two consecutive cycles
// - input latency through the check is one to two cycle times
// - one cycle is one complete I/O update of bridge and slaves
// - 64 points last 2.4ms, 128 points last 3.6ms per cycle
// - 256 points last 6.0ms, 512 points last 10.7ms per cycle
// - bridge processing adds 1.5ms in each direction; the code delays only the input area by it
// - line transmission budgeted as two cycle times per direction; BDC_LINE_CYCLES is not used by the code
// - parameter exchange runs on its own schedule, apart from I/O
// - auto parameter refresh every connected ids times cycle times 3
// - parameter read completes within target ids times cycle times 27
// - parameter write completes within target ids times cycle times 39
// - word slaves off word-range alignment are not validated correctly
// - new check setting applies only after save and then reset; reset clears the saved setting, so words_active stays 0
// - bit and 16-bit word granularity, words over leading range
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH
`define BDC_CLK_NS 4
`define BDC_CYC64_US 2400
`define BDC_CYC128_US 3600
`define BDC_CYC256_US 6000
`define BDC_CYC512_US 10700
`define BDC_BRIDGE_US 1500
`define BDC_LINE_CYCLES 2
`define BDC_AUTO_MULT 3
`define BDC_READ_MULT 27
`define BDC_WRITE_MULT 39
`define BDC_WORD_BITS 16
`define BDC_US2CYC(us) (((us) * 1000) / `BDC_CLK_NS)
`endif

// ===== bdc_pkg.sv
// types for the bridge double check block
package bdc_pkg;
    typedef enum logic [1:0] {
        BDC_PTS64 = 2'b00,
        BDC_PTS128 = 2'b01,
        BDC_PTS256 = 2'b10,
        BDC_PTS512 = 2'b11
    } bdc_pts_t;
    typedef enum logic [1:0] {
        BDC_PIDLE = 2'b00,
        BDC_PAUTO = 2'b01,
        BDC_PREAD = 2'b10,
        BDC_PWRITE = 2'b11
    } bdc_pst_t;
endpackage : bdc_pkg

// ===== bdc_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module bdc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bdc_fifo_st_t;
    bdc_fifo_st_t s_r, s_nxt;
    logic wr, rd;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two");
    end

    // full and empty come straight from the count
    always_comb begin
        s_nxt = s_r;
        in_ready = (s_r.cnt != DEPTH[AW:0]);
        out_valid = (s_r.cnt != '0);
        out_data = s_r.mem[s_r.rp];
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        if (wr) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (wr && !rd) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (rd && !wr) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : bdc_fifo

// ===== bdc_cell.sv
// one double check cell: a bit or a 16-bit word
`timescale 1ns/100ps
module bdc_cell #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sample,
    input wire logic [WIDTH-1:0] rx_val,
    output logic [WIDTH-1:0] valid_val
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] held;
        logic seen;
    } bdc_cell_st_t;
    bdc_cell_st_t s_r, s_nxt;

    initial begin
        if (WIDTH < 1)
            $error("cell width must be at least one");
    end

    // accept only on two equal successive receptions
    always_comb begin
        s_nxt = s_r;
        if (sample) begin
            if (s_r.seen && rx_val == s_r.prev)
                s_nxt.held = rx_val;
            s_nxt.prev = rx_val;
            s_nxt.seen = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign valid_val = s_r.held;
endmodule : bdc_cell

// ===== bdc_top_asserts.sv
// checker for the double check and cycle pacing block
`timescale 1ns/100ps
module bdc_top_asserts #(
    parameter int NIN = 256,
    parameter int CYC64 = 50,
    parameter int CYC128 = 60,
    parameter int CYC256 = 70,
    parameter int CYC512 = 80,
    parameter int BRIDGE_CYC = 5
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire bdc_pkg::bdc_pts_t cfg_points,
    input wire logic [NIN-1:0] rx_data,
    input wire logic rx_done,
    input wire logic cycle_start,
    input wire logic [NIN-1:0] in_area,
    input wire logic [15:0] out_word,
    input wire logic out_word_valid,
    input wire logic out_word_ready,
    input wire logic [7:0] conn_ids,
    input wire logic [7:0] tgt_ids,
    input wire logic prm_rd_req,
    input wire logic prm_wr_req,
    input wire logic prm_busy,
    input wire logic prm_done,
    input wire logic prm_auto_tick,
    input wire logic [4:0] words_active
);
    localparam int LAT = BRIDGE_CYC + 1;
    localparam int LAT2 = BRIDGE_CYC + 2;
    int len;
    logic [15:0] cnt_r, pc_r, ac_r;
    logic seen_r, rd_r;
    bdc_pkg::bdc_pts_t pts_r;
    logic [NIN-1:0] prev_r, exp_r, dif;
    wire logic take = cycle_start && rx_done;
    wire logic go = !prm_busy && (prm_rd_req || prm_wr_req);
    // expected cycle length for the live point count
    assign len = cfg_points == bdc_pkg::BDC_PTS64 ? CYC64 :
        cfg_points == bdc_pkg::BDC_PTS128 ? CYC128 :
        cfg_points == bdc_pkg::BDC_PTS256 ? CYC256 : CYC512;
    assign dif = rx_data ^ prev_r;
    // reference counters; a cycle cut by a config change is not judged
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 16'h0;
            pc_r <= 16'h0;
            ac_r <= 16'h0;
            seen_r <= 1'b0;
            rd_r <= 1'b0;
            pts_r <= bdc_pkg::BDC_PTS64;
            prev_r <= '0;
            exp_r <= '0;
        end else begin
            cnt_r <= cycle_start ? 16'h0 : cnt_r + 16'h1;
            pts_r <= cfg_points;
            if (cfg_points != pts_r) seen_r <= 1'b0;
            else if (cycle_start) seen_r <= 1'b1;
            if (take) prev_r <= rx_data;
            if (take) exp_r <= (rx_data & ~dif) | (exp_r & dif);
            if (go) rd_r <= prm_rd_req;
            pc_r <= go ? 16'h0 : pc_r + {15'h0, cycle_start && prm_busy};
            ac_r <= prm_auto_tick ? 16'h0 : ac_r + {15'h0, cycle_start};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_cycle_len: assert property (
        seen_r && cfg_points == pts_r |-> cycle_start == (cnt_r == len - 1))
        else $error("cycle length wrong");
    chk_start_pulse: assert property (
        cycle_start |=> !cycle_start) else $error("cycle pulse too long");
    chk_input_lat: assert property (
        take |-> ##[LAT:LAT2] in_area == exp_r)
        else $error("input area wrong after check");
    chk_prm_count: assert property (
        prm_done |-> pc_r == (rd_r ? 27 : 39) * tgt_ids)
        else $error("parameter access span wrong");
    chk_done_pulse: assert property (
        prm_done |=> !prm_done) else $error("done not a pulse");
    chk_auto_tick: assert property (
        prm_auto_tick |-> ac_r == conn_ids * 3)
        else $error("auto refresh spacing wrong");
    chk_out_hold: assert property (
        out_word_valid && !out_word_ready |=>
            out_word_valid && $stable(out_word))
        else $error("output word dropped while stalled");
    chk_words_hold: assert property (
        $stable(words_active)) else $error("setting applied without reset");
endmodule : bdc_top_asserts
bind bdc_top bdc_top_asserts #(.NIN(NIN), .CYC64(CYC64), .CYC128(CYC128),
    .CYC256(CYC256), .CYC512(CYC512), .BRIDGE_CYC(BRIDGE_CYC)) u_chk (
    .mclk, .nrst, .cfg_points, .rx_data, .rx_done, .cycle_start, .in_area,
    .out_word, .out_word_valid, .out_word_ready, .conn_ids, .tgt_ids,
    .prm_rd_req, .prm_wr_req, .prm_busy, .prm_done, .prm_auto_tick,
    .words_active);

// ===== bdc_slave.sv
// far side model: slave sweep per cycle and output word sink
`timescale 1ns/100ps
module bdc_slave #(
    parameter int NIN = 64
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cycle_start,
    input wire logic slow,
    input wire logic stall,
    input wire logic [NIN-1:0] field_in,
    output logic [NIN-1:0] rx_data,
    output logic rx_done,
    output logic out_word_ready
);
    logic [3:0] dly_r;
    // data alternates between the inverse and a stale copy until the sweep completes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dly_r <= 4'h0;
            rx_done <= 1'b0;
            rx_data <= '0;
            out_word_ready <= 1'b0;
        end else begin
            out_word_ready <= !stall;
            if (cycle_start) begin
                dly_r <= slow ? 4'hc : 4'h2;
                rx_done <= 1'b0;
                rx_data <= ~rx_data;
            end else if (dly_r == 4'h1) begin
                dly_r <= 4'h0;
                rx_done <= 1'b1;
                rx_data <= field_in; // word data on 16-bit starts
            end else if (dly_r != 4'h0) begin
                dly_r <= dly_r - 4'h1;
                rx_data <= ~rx_data;
            end
        end
    end
endmodule : bdc_slave

// ===== tb_top.sv
// bench: input double check, fifo path, cycle and parameter pacing
`timescale 1ns/100ps
module tb_top;
    localparam int NIN = 64;
    localparam int LENS [4] = '{50, 60, 70, 80};
    logic mclk = 0, nrst = 0, cfg_save = 0, rx_done, cycle_start;
    logic out_word_valid, out_word_ready, host_word_valid = 0;
    logic host_word_ready, prm_rd_req = 0, prm_wr_req = 0, prm_busy;
    logic prm_done, prm_auto_tick, slow = 0, stall = 0, run_in = 0;
    bdc_pkg::bdc_pts_t cfg_points = bdc_pkg::BDC_PTS64;
    logic [4:0] cfg_words_wr = 5'h00, words_active;
    logic [7:0] conn_ids = 8'h02, tgt_ids = 8'h01;
    logic [15:0] out_word, host_word = 16'h0000;
    logic [NIN-1:0] rx_data, in_area, field_in = '0;
    logic [NIN-1:0] prev_a = '0, exp_a = '0, last_a = '0, nx;
    logic [NIN-1:0] aq [$];
    logic [15:0] wq [$];
    int failures = 0, checks_done = 0, seed = 40, n, acc;
    bdc_top #(.NIN(NIN), .CYC64(50), .CYC128(60), .CYC256(70), .CYC512(80),
        .BRIDGE_CYC(5)) DUT (.mclk, .nrst, .cfg_points, .cfg_words_wr,
        .cfg_save, .rx_data, .rx_done, .cycle_start, .in_area, .out_word,
        .out_word_valid, .out_word_ready, .host_word, .host_word_valid,
        .host_word_ready, .conn_ids, .tgt_ids, .prm_rd_req, .prm_wr_req,
        .prm_busy, .prm_done, .prm_auto_tick, .words_active);
    bdc_slave #(.NIN(NIN)) u_slave (.mclk, .nrst, .cycle_start, .slow,
        .stall, .field_in, .rx_data, .rx_done, .out_word_ready);
    task automatic check(string what, logic [NIN-1:0] e, logic [NIN-1:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic wait_start(output int k);
        for (k = 1; k < 1000; k++) begin
            @(negedge mclk);
            if (cycle_start === 1'b1) break;
        end
    endtask : wait_start
    task automatic push();
        logic [15:0] w;
        w = 16'($random(seed));
        @(posedge mclk);
        host_word <= w;
        host_word_valid <= 1'b1;
        @(negedge mclk);
        if (host_word_ready === 1'b1) wq.push_back(w);
        if (host_word_ready === 1'b1) acc++;
        @(posedge mclk);
        host_word_valid <= 1'b0;
    endtask : push
    task automatic prm(logic rd, logic wr, logic [7:0] t);
        int k;
        @(posedge mclk);
        tgt_ids <= t;
        prm_rd_req <= rd;
        prm_wr_req <= wr;
        n = 0;
        for (k = 0; k < 100 && prm_busy !== 1'b1; k++) @(negedge mclk);
        // the first busy clock may already carry a cycle pulse
        if (prm_busy === 1'b1 && cycle_start === 1'b1) n++;
        @(posedge mclk);
        prm_rd_req <= 1'b0;
        prm_wr_req <= 1'b0;
        for (k = 0; k < 9000 && prm_done !== 1'b1; k++) begin
            @(negedge mclk);
            if (cycle_start === 1'b1) n++;
        end
        check("prm_pulses", (rd ? 27 : 39) * t, n);
    endtask : prm
    initial forever #2 mclk = ~mclk;
    // watchdog sized well past the longest parameter access
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    // field inputs: half the time held past two cycles, half the time a short glitch
    initial begin
        wait (run_in);
        forever begin
            @(posedge mclk);
            field_in <= {$random(seed), $random(seed)};
            repeat (($random(seed) & 1) ? 20 : 200) @(posedge mclk);
        end
    end
    // notes each new area that an accepted sample should give
    always @(posedge mclk) begin
        if (cycle_start === 1'b1 && rx_done === 1'b1) begin
            nx = (rx_data & ~(rx_data ^ prev_a)) | (exp_a & (rx_data ^ prev_a));
            prev_a = rx_data;
            if (nx !== exp_a) aq.push_back(nx);
            exp_a = nx;
        end
    end
    // scoreboard: oldest note against each result that appears
    always @(negedge mclk) begin
        if (nrst && in_area !== last_a) begin
            last_a = in_area;
            check("in_area", aq.size() ? aq.pop_front() : ~in_area, in_area);
        end
        if (out_word_valid === 1'b1 && out_word_ready === 1'b1)
            check("out_word", wq.size() ? wq.pop_front() : ~out_word, out_word);
    end
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        cfg_words_wr <= 5'h03;
        cfg_save <= 1'b1;
        repeat (4) @(posedge mclk);
        cfg_save <= 1'b0;
        nrst <= 1'b0;
        @(negedge mclk);
        check("words_active", 0, words_active);
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        check("words_active", 0, words_active);
        run_in = 1;
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            cfg_points <= bdc_pkg::bdc_pts_t'(m);
            slow <= m[0];
            repeat (4) wait_start(n);
            check("cycle_len", LENS[m], n);
        end
        prm(1'b1, 1'b0, 8'h01);
        prm(1'b0, 1'b1, 8'h01);
        prm(1'b1, 1'b1, 8'h02);
        stall <= 1'b1;
        acc = 0;
        repeat (20) push();
        check("fifo_fill", 1, acc >= 16 && acc <= 18);
        stall <= 1'b0;
        repeat (60) @(posedge mclk);
        check("fifo_left", 0, wq.size());
        report_and_stop();
    end
endmodule : tb_top
